// *** core/rcs_remote_cal.sv ***
`timescale 1ns/1ps
`include "rcs_defs.svh"

// How it works
// - Zero request while contact open starts zero
// - Span request while contact open starts span
// - Run ends on cal_run_done, not when its request drops
// - Contact closed exactly while any run active
// - Requests sampled only when analyzing, contact open
// - Requests during a run dropped, never stored
// - Request still high at end repeats run
// - Internal valves follow analysis or calibration mode
// - Range relays one-hot: low, medium, high, aircal
// - Status message every interval while enabled
// - Message: concentration, range, span, alarms
// - Autospan command plus CR starts span
// - Autozero command plus CR starts zero
// - Status-toggle command plus CR inverts output enable
// - Serial 2400 baud, 8 bits, no parity, 1 stop
// - Four valve drive lines, each on or off
module rcs_remote_cal #(
    parameter int unsigned BAUD_CYCLES = `RCS_BAUD_CYCLES,
    parameter int unsigned STATUS_CYCLES = `RCS_STATUS_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic zero_req,
    input wire logic span_req,
    input wire logic cal_run_done,
    input wire logic valve_opt_fitted,
    input wire rcs_pkg::rcs_status_t status_in,
    input wire logic rxd,
    output logic txd,
    output logic cal_contact,
    output logic zero_mode,
    output logic span_mode,
    output rcs_pkg::rcs_valve_t valve,
    output logic [3:0] range_relay,
    output logic status_enable
);
    import rcs_pkg::*;

    // ************************************************************
    // Calibration sequencing
    // ************************************************************
    rcs_cal_state_t cal_state;
    rcs_cal_state_t next_cal_state;
    logic span_after_zero;
    logic next_span_after_zero;
    logic autozero_cmd;
    logic autospan_cmd;

    always_comb begin
        next_cal_state = cal_state;
        next_span_after_zero = span_after_zero;
        case (cal_state)
            RCS_CAL_ANALYZE: begin
                // Inputs only looked at here, so requests during a
                // run are simply never seen
                if (zero_req || autozero_cmd) begin
                    next_cal_state = RCS_CAL_ZERO;
                    next_span_after_zero = span_req | autospan_cmd;
                end else if (span_req || autospan_cmd) begin
                    next_cal_state = RCS_CAL_SPAN;
                end
            end
            RCS_CAL_ZERO: begin
                if (cal_run_done) begin
                    if (span_after_zero) begin
                        next_cal_state = RCS_CAL_SPAN;
                        next_span_after_zero = 1'b0;
                    end else begin
                        // Back to analysis; a request still held is
                        // polled again and restarts the run
                        next_cal_state = RCS_CAL_ANALYZE;
                    end
                end
            end
            RCS_CAL_SPAN: begin
                if (cal_run_done) begin
                    next_cal_state = RCS_CAL_ANALYZE;
                end
            end
            default: begin
                next_cal_state = RCS_CAL_ANALYZE;
                next_span_after_zero = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cal_state <= RCS_CAL_ANALYZE;
            span_after_zero <= 1'b0;
        end else begin
            cal_state <= next_cal_state;
            span_after_zero <= next_span_after_zero;
        end
    end

    // ************************************************************
    // Contact, mode and valve outputs
    // ************************************************************
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cal_contact <= 1'b0;
            zero_mode <= 1'b0;
            span_mode <= 1'b0;
        end else begin
            cal_contact <= next_cal_state != RCS_CAL_ANALYZE;
            zero_mode <= next_cal_state == RCS_CAL_ZERO;
            span_mode <= next_cal_state == RCS_CAL_SPAN;
        end
    end

    // Lines stay off without the valve option; external valves are
    // then steered from zero_mode and span_mode instead.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            valve <= '0;
        end else if (valve_opt_fitted) begin
            valve.sample <= next_cal_state == RCS_CAL_ANALYZE;
            valve.zero <= next_cal_state == RCS_CAL_ZERO;
            valve.span <= next_cal_state == RCS_CAL_SPAN;
            valve.exhaust <= 1'b1;
        end else begin
            valve <= '0;
        end
    end

    // ************************************************************
    // Range identification relays
    // ************************************************************
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            range_relay <= 4'h0;
        end else begin
            range_relay <= 4'h1 << status_in.range;
        end
    end

    // ************************************************************
    // Serial receiver
    // ************************************************************
    rcs_rx_state_t rx_state;
    logic [31:0] rx_cnt;
    logic [3:0] rx_bits;
    logic [7:0] rx_shift;
    logic rx_valid;
    logic [7:0] rx_byte;

    // Middle of each bit is sampled: half a bit after the start edge,
    // then one full bit apart
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rx_state <= RCS_RX_IDLE;
            rx_cnt <= 32'h0;
            rx_bits <= 4'h0;
            rx_shift <= 8'h00;
            rx_valid <= 1'b0;
            rx_byte <= 8'h00;
        end else begin
            rx_valid <= 1'b0;
            case (rx_state)
                RCS_RX_IDLE: begin
                    rx_cnt <= 32'h0;
                    if (!rxd) begin
                        rx_state <= RCS_RX_START;
                    end
                end
                RCS_RX_START: begin
                    if (rx_cnt >= BAUD_CYCLES / 2 - 1) begin
                        rx_cnt <= 32'h0;
                        rx_bits <= 4'h0;
                        // A glitch that is gone by mid-bit is no start
                        rx_state <= rxd ? RCS_RX_IDLE : RCS_RX_DATA;
                    end else begin
                        rx_cnt <= rx_cnt + 32'h1;
                    end
                end
                RCS_RX_DATA: begin
                    if (rx_cnt >= BAUD_CYCLES - 1) begin
                        rx_cnt <= 32'h0;
                        rx_shift <= {rxd, rx_shift[7:1]};
                        rx_bits <= rx_bits + 4'h1;
                        if (rx_bits == `RCS_DATA_BITS - 4'h1) begin
                            rx_state <= RCS_RX_STOP;
                        end
                    end else begin
                        rx_cnt <= rx_cnt + 32'h1;
                    end
                end
                RCS_RX_STOP: begin
                    if (rx_cnt >= BAUD_CYCLES - 1) begin
                        rx_cnt <= 32'h0;
                        rx_state <= RCS_RX_IDLE;
                        // Framing error: byte dropped silently
                        if (rxd) begin
                            rx_valid <= 1'b1;
                            rx_byte <= rx_shift;
                        end
                    end else begin
                        rx_cnt <= rx_cnt + 32'h1;
                    end
                end
                default: begin
                    rx_state <= RCS_RX_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Command parser
    // ************************************************************
    logic [7:0] last_ch;
    logic [7:0] prev_ch;
    logic cr_seen;
    logic status_toggle_cmd;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            last_ch <= 8'h00;
            prev_ch <= 8'h00;
        end else if (rx_valid) begin
            // A CR clears history so a bare CR never repeats a command
            prev_ch <= (rx_byte == `RCS_CH_CR) ? 8'h00 : last_ch;
            last_ch <= (rx_byte == `RCS_CH_CR) ? 8'h00 : rx_byte;
        end
    end

    assign cr_seen = rx_valid && (rx_byte == `RCS_CH_CR);
    assign autospan_cmd = cr_seen && prev_ch == `RCS_CH_A
        && last_ch == `RCS_CH_S;
    assign autozero_cmd = cr_seen && prev_ch == `RCS_CH_A
        && last_ch == `RCS_CH_Z;
    assign status_toggle_cmd = cr_seen && prev_ch == `RCS_CH_S
        && last_ch == `RCS_CH_T;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            status_enable <= `RCS_STATUS_EN_RST;
        end else if (status_toggle_cmd) begin
            status_enable <= !status_enable;
        end
    end

    // ************************************************************
    // Status message generation
    // ************************************************************
    logic [31:0] period_cnt;
    logic period_tick;
    rcs_status_t snap;
    logic msg_active;
    logic [4:0] msg_idx;
    logic tx_busy;
    logic [31:0] tx_cnt;
    logic [3:0] tx_bits;
    logic [9:0] tx_shift;

    function automatic logic [7:0] hex_ch(input logic [3:0] n);
        hex_ch = (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction

    // Fixed layout: CCCC R SSSSD?T? CR LF
    function automatic logic [7:0] msg_byte(input logic [4:0] i,
            input rcs_status_t s);
        logic [7:0] rng;
        rng = (s.range == RCS_RANGE_LO) ? 8'h4c :
              (s.range == RCS_RANGE_MED) ? 8'h4d :
              (s.range == RCS_RANGE_HI) ? 8'h48 : 8'h41;
        case (i)
            5'h0: msg_byte = hex_ch(s.conc[15:12]);
            5'h1: msg_byte = hex_ch(s.conc[11:8]);
            5'h2: msg_byte = hex_ch(s.conc[7:4]);
            5'h3: msg_byte = hex_ch(s.conc[3:0]);
            5'h4: msg_byte = `RCS_CH_SP;
            5'h5: msg_byte = rng;
            5'h6: msg_byte = `RCS_CH_SP;
            5'h7: msg_byte = hex_ch(s.span[15:12]);
            5'h8: msg_byte = hex_ch(s.span[11:8]);
            5'h9: msg_byte = hex_ch(s.span[7:4]);
            5'ha: msg_byte = hex_ch(s.span[3:0]);
            5'hb: msg_byte = 8'h44;
            5'hc: msg_byte = hex_ch({2'h0, s.alarm_disabled});
            5'hd: msg_byte = 8'h54;
            5'he: msg_byte = hex_ch({2'h0, s.alarm_tripped});
            5'hf: msg_byte = `RCS_CH_CR;
            default: msg_byte = `RCS_CH_LF;
        endcase
    endfunction

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            period_cnt <= 32'h0;
            period_tick <= 1'b0;
        end else if (period_cnt >= STATUS_CYCLES - 1) begin
            period_cnt <= 32'h0;
            period_tick <= 1'b1;
        end else begin
            period_cnt <= period_cnt + 32'h1;
            period_tick <= 1'b0;
        end
    end

    // A message already started is always finished, so the far end
    // never sees a torn line when output is switched off.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            msg_active <= 1'b0;
            msg_idx <= 5'h0;
            snap <= '0;
        end else if (!msg_active) begin
            if (period_tick && status_enable) begin
                msg_active <= 1'b1;
                msg_idx <= 5'h0;
                snap <= status_in;
            end
        end else if (!tx_busy) begin
            if (msg_idx == `RCS_MSG_LEN - 5'h1) begin
                msg_active <= 1'b0;
            end
            msg_idx <= msg_idx + 5'h1;
        end
    end

    // ************************************************************
    // Serial transmitter
    // ************************************************************
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tx_busy <= 1'b0;
            tx_cnt <= 32'h0;
            tx_bits <= 4'h0;
            tx_shift <= 10'h3ff;
            txd <= 1'b1;
        end else if (!tx_busy) begin
            txd <= 1'b1;
            if (msg_active) begin
                // Stop, data LSB first, start: no parity
                tx_shift <= {1'b1, msg_byte(msg_idx, snap), 1'b0};
                tx_busy <= 1'b1;
                tx_cnt <= 32'h0;
                tx_bits <= 4'h0;
            end
        end else begin
            txd <= tx_shift[0];
            if (tx_cnt >= BAUD_CYCLES - 1) begin
                tx_cnt <= 32'h0;
                tx_shift <= {1'b1, tx_shift[9:1]};
                tx_bits <= tx_bits + 4'h1;
                if (tx_bits == `RCS_FRAME_BITS - 4'h1) begin
                    tx_busy <= 1'b0;
                end
            end else begin
                tx_cnt <= tx_cnt + 32'h1;
            end
        end
    end

endmodule // rcs_remote_cal

// *** inc/rcs_defs.svh ***
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define RCS_CLK_HZ 40000000
`define RCS_BAUD_HZ 2400
`define RCS_STATUS_MS 2000
`define RCS_BAUD_CYCLES (`RCS_CLK_HZ / `RCS_BAUD_HZ)
`define RCS_STATUS_CYCLES (`RCS_STATUS_MS * (`RCS_CLK_HZ / 1000))

// ****************************************************************
// Character framing
// ****************************************************************
`define RCS_DATA_BITS 4'h8
`define RCS_FRAME_BITS 4'ha

// ****************************************************************
// Command characters
// ****************************************************************
`define RCS_CH_A 8'h61
`define RCS_CH_S 8'h73
`define RCS_CH_Z 8'h7a
`define RCS_CH_T 8'h74
`define RCS_CH_CR 8'h0d
`define RCS_CH_LF 8'h0a
`define RCS_CH_SP 8'h20

// ****************************************************************
// Status message
// ****************************************************************
`define RCS_MSG_LEN 5'h11
`define RCS_STATUS_EN_RST 1'b1

`endif

// *** inc/rcs_pkg.sv ***
package rcs_pkg;

    typedef enum logic [1:0] {
        RCS_RANGE_LO,
        RCS_RANGE_MED,
        RCS_RANGE_HI,
        RCS_RANGE_AIRCAL
    } rcs_range_t;

    typedef enum {
        RCS_CAL_ANALYZE,
        RCS_CAL_ZERO,
        RCS_CAL_SPAN
    } rcs_cal_state_t;

    typedef enum {
        RCS_RX_IDLE,
        RCS_RX_START,
        RCS_RX_DATA,
        RCS_RX_STOP
    } rcs_rx_state_t;

    typedef struct packed {
        logic sample;
        logic span;
        logic zero;
        logic exhaust;
    } rcs_valve_t;

    typedef struct packed {
        logic [15:0] conc;
        rcs_range_t range;
        logic [15:0] span;
        logic [1:0] alarm_disabled;
        logic [1:0] alarm_tripped;
    } rcs_status_t;

endpackage

// *** sim/rcs_host_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Plant controller: serial line and external gas valves
// ****************************************************************
module rcs_host_model #(
    parameter int unsigned BAUD_CYCLES = 16
) (
    input wire logic mclk,
    input wire logic txd,
    input wire logic zero_mode,
    input wire logic span_mode,
    output logic rxd,
    output logic ext_zero_valve,
    output logic ext_span_valve
);
    logic [7:0] rxq[$];
    logic [7:0] b;
    assign ext_zero_valve = zero_mode;
    assign ext_span_valve = span_mode;
    initial rxd = 1'b1;
    // One 8N1 character, LSB first; line left idle high
    task automatic send_byte(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk);
            rxd <= f[i];
            repeat (BAUD_CYCLES - 1) @(posedge mclk);
        end
    endtask
    // Receiver samples mid-bit, so a late start edge costs one cycle only
    initial begin
        forever begin
            @(posedge mclk);
            if (txd === 1'b0) begin
                repeat (BAUD_CYCLES / 2) @(posedge mclk);
                for (int i = 0; i < 8; i++) begin
                    repeat (BAUD_CYCLES) @(posedge mclk);
                    b[i] = txd;
                end
                repeat (BAUD_CYCLES) @(posedge mclk);
                rxq.push_back(b);
            end
        end
    end
endmodule // rcs_host_model

// *** sim/rcs_remote_cal_assertions.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Port checks for the remote calibration block
// ****************************************************************
module rcs_remote_cal_assertions #(
    parameter int unsigned BAUD_CYCLES = 16,
    parameter int unsigned STATUS_CYCLES = 4000
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic zero_req,
    input wire logic span_req,
    input wire logic cal_run_done,
    input wire logic valve_opt_fitted,
    input wire rcs_pkg::rcs_status_t status_in,
    input wire logic txd,
    input wire logic cal_contact,
    input wire logic zero_mode,
    input wire logic span_mode,
    input wire rcs_pkg::rcs_valve_t valve,
    input wire logic [3:0] range_relay
);
    import rcs_pkg::*;
    logic txd_q;
    logic [31:0] run;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // Length of the current txd level; every low span must be whole bits
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            txd_q <= 1'b1;
            run <= 32'h0;
        end else begin
            txd_q <= txd;
            run <= (txd != txd_q) ? 32'h1 : run + 32'h1;
        end
    end
    property p_zero_start;
        !cal_contact && zero_req |=> cal_contact && zero_mode && !span_mode;
    endproperty
    a_zero_start: assert property (p_zero_start)
        else $error("zero request not taken");
    property p_span_start;
        !cal_contact && span_req && !zero_req |=> cal_contact && span_mode;
    endproperty
    a_span_start: assert property (p_span_start)
        else $error("span request not taken");
    property p_contact;
        cal_contact == (zero_mode || span_mode);
    endproperty
    a_contact: assert property (p_contact)
        else $error("contact does not match run");
    property p_hold;
        cal_contact && !cal_run_done |=> $stable(zero_mode) && $stable(span_mode);
    endproperty
    a_hold: assert property (p_hold)
        else $error("mode changed during a run");
    property p_span_end;
        span_mode && cal_run_done |=> !cal_contact;
    endproperty
    a_span_end: assert property (p_span_end)
        else $error("contact stays closed after run");
    property p_repeat;
        span_mode && cal_run_done && span_req && !zero_req
            |=> !cal_contact ##1 span_mode;
    endproperty
    a_repeat: assert property (p_repeat)
        else $error("held request did not repeat run");
    property p_valve_on;
        valve_opt_fitted && $past(valve_opt_fitted) && $past(rst_b)
            |-> valve == {!cal_contact, span_mode, zero_mode, 1'b1};
    endproperty
    a_valve_on: assert property (p_valve_on)
        else $error("internal valves do not follow mode");
    property p_valve_off;
        !valve_opt_fitted && !$past(valve_opt_fitted) && $past(rst_b)
            |-> valve == 4'h0;
    endproperty
    a_valve_off: assert property (p_valve_off)
        else $error("valve driven without option");
    property p_range;
        $past(rst_b) |-> range_relay == 4'h1 << $past(status_in.range);
    endproperty
    a_range: assert property (p_range)
        else $error("range relays wrong");
    property p_baud;
        txd && !txd_q |-> run != 0 && run % BAUD_CYCLES == 0;
    endproperty
    a_baud: assert property (p_baud)
        else $error("serial bit width wrong");
    c_zero: cover property (zero_mode && cal_run_done);
    c_repeat: cover property (span_mode && cal_run_done && span_req);
    c_both: cover property (!cal_contact && zero_req && span_req);
    c_frame: cover property (txd && !txd_q);
endmodule // rcs_remote_cal_assertions

bind rcs_remote_cal rcs_remote_cal_assertions #(
    .BAUD_CYCLES(BAUD_CYCLES),
    .STATUS_CYCLES(STATUS_CYCLES)
) u_chk (.mclk(mclk), .rst_b(rst_b), .zero_req(zero_req),
    .span_req(span_req), .cal_run_done(cal_run_done),
    .valve_opt_fitted(valve_opt_fitted), .status_in(status_in),
    .txd(txd), .cal_contact(cal_contact), .zero_mode(zero_mode),
    .span_mode(span_mode), .valve(valve), .range_relay(range_relay));

// *** sim/tb_rcs_remote_cal.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Testbench for the remote calibration block
// ****************************************************************
module tb_rcs_remote_cal;
    import rcs_pkg::*;
    localparam int unsigned BAUD = 16;
    localparam int unsigned STAT = 4000;
    logic mclk, rst_b, zero_req, span_req, cal_run_done, valve_opt_fitted;
    logic rxd, txd, cal_contact, zero_mode, span_mode, status_enable;
    rcs_status_t status_in;
    rcs_valve_t valve;
    logic [3:0] range_relay;
    int failures, checked;
    string msg = "1234 M 5678D2T1\015\012";

    rcs_remote_cal #(.BAUD_CYCLES(BAUD), .STATUS_CYCLES(STAT)) dut (
        .mclk(mclk), .rst_b(rst_b), .zero_req(zero_req),
        .span_req(span_req), .cal_run_done(cal_run_done),
        .valve_opt_fitted(valve_opt_fitted), .status_in(status_in),
        .rxd(rxd), .txd(txd), .cal_contact(cal_contact),
        .zero_mode(zero_mode), .span_mode(span_mode), .valve(valve),
        .range_relay(range_relay), .status_enable(status_enable));
    rcs_host_model #(.BAUD_CYCLES(BAUD)) host (.mclk(mclk), .txd(txd),
        .zero_mode(zero_mode), .span_mode(span_mode), .rxd(rxd),
        .ext_zero_valve(), .ext_span_valve());

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wait_contact(input logic v);
        int n;
        n = 0;
        while (cal_contact !== v && n < 50) begin
            cyc(1);
            n++;
        end
        chk(cal_contact, v);
    endtask
    // Pulse lands on one edge; outputs are settled on return
    task automatic done_pulse;
        @(posedge mclk);
        cal_run_done <= 1'b1;
        @(posedge mclk);
        cal_run_done <= 1'b0;
        #1;
    endtask
    task automatic send_cmd(input logic [7:0] c1, input logic [7:0] c2);
        host.send_byte(c1);
        host.send_byte(c2);
        host.send_byte(8'h0d);
        #1;
    endtask
    task automatic req(input logic z, input logic s);
        @(posedge mclk);
        zero_req <= z;
        span_req <= s;
    endtask

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        repeat (60000) @(posedge mclk);
        failures++;
        stop_test;
    end
    initial begin
        rst_b = 1'b0;
        zero_req = 1'b0;
        span_req = 1'b0;
        cal_run_done = 1'b0;
        valve_opt_fitted = 1'b1;
        status_in = {16'h1234, RCS_RANGE_MED, 16'h5678, 2'h2, 2'h1};
        failures = 0;
        checked = 0;
        cyc(7);
        chk({txd, cal_contact, status_enable, valve, range_relay}, 11'h500);
        @(posedge mclk);
        rst_b <= 1'b1;
        cyc(2);
        $display("test reset done");
        req(1'b1, 1'b0);
        wait_contact(1'b1);
        chk(valve, 4'b0011);
        req(1'b0, 1'b0);
        cyc(5);
        chk(cal_contact, 1'b1);
        done_pulse;
        chk({cal_contact, zero_mode, valve}, 6'b001001);
        req(1'b0, 1'b1);
        wait_contact(1'b1);
        done_pulse;
        chk(cal_contact, 1'b0);
        cyc(1);
        chk({cal_contact, span_mode}, 2'b11);
        req(1'b0, 1'b0);
        done_pulse;
        chk(cal_contact, 1'b0);
        $display("test handshake done");
        req(1'b1, 1'b0);
        wait_contact(1'b1);
        req(1'b0, 1'b1);
        cyc(3);
        req(1'b0, 1'b0);
        done_pulse;
        cyc(4);
        chk(cal_contact, 1'b0);
        req(1'b1, 1'b1);
        wait_contact(1'b1);
        chk({zero_mode, span_mode}, 2'b10);
        req(1'b0, 1'b0);
        done_pulse;
        chk({cal_contact, span_mode, valve}, 6'b110101);
        done_pulse;
        chk(cal_contact, 1'b0);
        $display("test discard done");
        @(posedge mclk);
        valve_opt_fitted <= 1'b0;
        send_cmd(8'h61, 8'h7a);
        chk({zero_mode, valve}, 5'h10);
        send_cmd(8'h61, 8'h73);
        chk({zero_mode, span_mode}, 2'b10);
        done_pulse;
        send_cmd(8'h7a, 8'h61);
        chk(cal_contact, 1'b0);
        send_cmd(8'h61, 8'h73);
        chk(span_mode, 1'b1);
        done_pulse;
        @(posedge mclk);
        valve_opt_fitted <= 1'b1;
        $display("test serial commands done");
        for (int r = 0; r < 4; r++) begin
            @(posedge mclk);
            status_in.range <= rcs_range_t'(r);
            cyc(2);
            chk(range_relay, 4'h1 << r);
        end
        @(posedge mclk);
        status_in.range <= RCS_RANGE_MED;
        $display("test range done");
        send_cmd(8'h73, 8'h74);
        chk(status_enable, 1'b0);
        cyc(3000);
        host.rxq.delete();
        cyc(2 * STAT);
        chk(host.rxq.size(), 0);
        send_cmd(8'h73, 8'h74);
        chk(status_enable, 1'b1);
        for (int k = 0; k < STAT + 3000 && host.rxq.size() < 17; k++) begin
            cyc(1);
        end
        chk(host.rxq.size() >= 17, 1'b1);
        for (int i = 0; i < 17; i++) begin
            chk(host.rxq[i], msg[i]);
        end
        $display("test status done");
        stop_test;
    end
endmodule // tb_rcs_remote_cal
